// file: srcc_pkg.sv
// Constants for the standby, reset and clock control block.
// Assumes a single 200 MHz system clock and a synchronous active-high reset.
`default_nettype none
package srcc_pkg;
  // ****************************************
  // Standby modes
  // ****************************************
  typedef enum logic [2:0] {
    SRCC_RUN  = 3'b001,
    SRCC_HALT = 3'b010,
    SRCC_STOP = 3'b100
  } srcc_mode_t;

  // ****************************************
  // Widths and counts
  // ****************************************
  localparam int unsigned SRCC_CS_W      = 7;
  localparam int unsigned SRCC_CAS_W     = 4;
  localparam int unsigned SRCC_DACK_W    = 4;
  localparam int unsigned SRCC_ADDR_W    = 23;
  localparam int unsigned SRCC_DATA_W    = 32;
  localparam int unsigned SRCC_PORT_W    = 3;
  localparam int unsigned SRCC_TRACE_W   = 4;
  localparam int unsigned SRCC_FILT_LEN  = 4;   // Equal samples needed by the noise filter
  localparam int unsigned SRCC_CPU_MULT  = 3;   // CPU clock ticks per bus clock
  localparam int unsigned SRCC_BUS_DIV   = 3;   // System clocks per bus clock phase group
  localparam int unsigned SRCC_CLK_PS    = 5000;
  localparam int unsigned SRCC_WAKE_NS   = 100; // Gated clock restart time
  localparam int unsigned SRCC_WAKE_CYC  = (SRCC_WAKE_NS * 1000 + SRCC_CLK_PS - 1) / SRCC_CLK_PS;
  localparam logic [1:0]  SRCC_BUS_CNT_RST = 2'h0;
endpackage : srcc_pkg
`default_nettype wire

// file: srcc_filter.sv
// Noise-rejection filter for one asynchronous input pin.
// Assumes the pin is asynchronous to sys_clk; it passes two flip-flops first.
`default_nettype none
module srcc_filter #(
  parameter int unsigned LEN   = srcc_pkg::SRCC_FILT_LEN,
  parameter logic        RST_V = 1'b0
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic pin_in,
  output logic      filt_out
);
  import srcc_pkg::*;

  initial begin
    if (LEN < 2 || LEN > 15) $error("srcc_filter: LEN out of range");
  end

  logic       sync0_reg;
  logic       sync1_reg;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic       out_reg;
  wire        differs = (sync1_reg != out_reg);
  wire        settled = (cnt_reg == 4'(LEN - 1));

  // Two-stage synchroniser
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync0_reg <= RST_V;
      sync1_reg <= RST_V;
    end else begin
      sync0_reg <= pin_in;
      sync1_reg <= sync0_reg;
    end
  end

  // Count consecutive samples that differ from the output
  assign cnt_next = !differs ? 4'h0 : (settled ? 4'h0 : cnt_reg + 4'h1);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_reg <= 4'h0;
      out_reg <= RST_V;
    end else begin
      cnt_reg <= cnt_next;
      if (differs && settled) out_reg <= sync1_reg;
    end
  end

  assign filt_out = out_reg;

  property p_filt_stable;
    @(posedge sys_clk) disable iff (rst)
      (out_reg != $past(out_reg)) |-> ($past(sync1_reg) == out_reg);
  endproperty
  a_filt_stable: assert property (p_filt_stable) else $error("filter changed without input");
endmodule : srcc_filter
`default_nettype wire

// file: srcc_top.sv
// Standby, reset and clock control: bus and CPU clock enables, HALT and
// STOP control, pin levels during standby and reset, filtered reset and NMI.
// Assumes one 200 MHz sys_clk; pins are asynchronous and pass a filter.
`default_nettype none

// Overview of operation
// - In HALT the oscillator and PLL stay on while the CPU clock stops.
// - In HALT the peripherals keep their clock and keep running.
// - In STOP the PLL, bus clock, CPU and peripherals all stop, the oscillator runs.
// - A bus clock is produced and a CPU clock at three times its rate.
// - In HALT address is undefined, strobes and selects are high, all float under hold grant.
// - In STOP column strobes and refresh run self refresh, or hold their levels if disabled.
// - In HALT the row strobe holds its level until a refresh, then goes high.
// - A DMA transfer during HALT makes every pin behave as in normal operation.
// - Reset and NMI inputs pass a sampling noise filter.
// - The debug unit can force reset, mask reset and mask NMI.
// - During reset strobes, selects, grants and serial out are high, the clock pin toggles.
// - After reset data, port and timer pins float, address is undefined.
module srcc_top #(
  parameter int unsigned WAKE_CYC = srcc_pkg::SRCC_WAKE_CYC
) (
  input  wire logic                                sys_clk,
  input  wire logic                                rst,
  input  wire logic                                reset_pin_n,
  input  wire logic                                nmi_pin,
  input  wire logic                                dbg_force_reset,
  input  wire logic                                dbg_mask_reset,
  input  wire logic                                dbg_mask_nmi,
  input  wire logic                                halt_req,
  input  wire logic                                stop_req,
  input  wire logic                                irq_pending,
  input  wire logic                                self_refresh_en,
  input  wire logic                                dma_active,
  input  wire logic                                cbr_done,
  input  wire logic                                hold_grant_n,
  input  wire logic [srcc_pkg::SRCC_CS_W-1:0]      cs_core,
  input  wire logic                                bcs_core,
  input  wire logic [3:0]                          strobe_core,
  input  wire logic [srcc_pkg::SRCC_CAS_W-1:0]     cas_core,
  input  wire logic                                ras_core,
  input  wire logic                                refresh_core,
  input  wire logic [srcc_pkg::SRCC_CAS_W-1:0]     cas_selfref,
  input  wire logic                                refresh_selfref,
  input  wire logic                                hold_grant_core_n,
  input  wire logic [srcc_pkg::SRCC_DACK_W-1:0]    dack_core,
  input  wire logic                                txd_core,
  input  wire logic                                tc_core,
  input  wire logic                                data_oe_core,
  input  wire logic                                addr_oe_core,
  input  wire logic [srcc_pkg::SRCC_PORT_W-1:0]    port_oe_core,
  input  wire logic [1:0]                          timer_oe_core,
  output logic                                     bus_clk_en,
  output logic                                     cpu_clk_en,
  output logic                                     periph_clk_en,
  output logic                                     pll_run,
  output logic                                     osc_run,
  output logic                                     clock_output_pin,
  output logic                                     sys_reset,
  output logic                                     nmi_req,
  output logic                                     cpu_resume,
  output srcc_pkg::srcc_mode_t                     mode,
  output logic [srcc_pkg::SRCC_CS_W-1:0]           chip_select_lines,
  output logic                                     bus_cycle_start_strobe,
  output logic [3:0]                               strobe_pins,
  output logic                                     column_strobe_byte0,
  output logic                                     column_strobe_byte1,
  output logic                                     column_strobe_byte2,
  output logic                                     column_strobe_byte3,
  output logic                                     row_strobe,
  output logic                                     refresh_request_out,
  output logic                                     hold_grant_out_n,
  output logic [srcc_pkg::SRCC_DACK_W-1:0]         transfer_grant_lines,
  output logic                                     serial_tx,
  output logic                                     terminal_count_out,
  output logic                                     ctrl_oe,
  output logic                                     data_bus_oe,
  output logic                                     address_oe,
  output logic [srcc_pkg::SRCC_PORT_W-1:0]         general_pins_oe,
  output logic                                     timer_output_a_oe,
  output logic                                     timer_output_b_oe
);
  import srcc_pkg::*;

  initial begin
    if (WAKE_CYC < 1 || WAKE_CYC > 65535) $error("srcc_top: WAKE_CYC out of range");
  end

  // ****************************************
  // Reset and NMI filtering
  // ****************************************
  logic reset_filt_n;
  logic nmi_filt;

  srcc_filter #(.LEN(SRCC_FILT_LEN), .RST_V(1'b0)) u_reset_filt (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .pin_in   (reset_pin_n),
    .filt_out (reset_filt_n)
  );

  srcc_filter #(.LEN(SRCC_FILT_LEN), .RST_V(1'b0)) u_nmi_filt (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .pin_in   (nmi_pin),
    .filt_out (nmi_filt)
  );

  // Debug overrides on the filtered inputs
  wire  reset_take = dbg_force_reset | (~reset_filt_n & ~dbg_mask_reset);
  wire  nmi_take   = nmi_filt & ~dbg_mask_nmi;
  logic nmi_d_reg;
  logic sys_reset_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sys_reset_reg <= 1'b1;
      nmi_d_reg     <= 1'b0;
    end else begin
      sys_reset_reg <= reset_take;
      nmi_d_reg     <= nmi_take;
    end
  end

  wire nmi_edge = nmi_take & ~nmi_d_reg;
  assign sys_reset = sys_reset_reg;
  assign nmi_req   = nmi_edge;

  // ****************************************
  // Standby state machine
  // ****************************************
  srcc_mode_t mode_reg;
  srcc_mode_t mode_next;
  logic [15:0] wake_reg;
  logic [15:0] wake_next;
  wire  wake_evt  = reset_take | nmi_edge | irq_pending;
  wire  in_halt   = (mode_reg == SRCC_HALT);
  wire  in_stop   = (mode_reg == SRCC_STOP);
  wire  waking    = (wake_reg != 16'h0);

  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      SRCC_RUN: begin
        if (!waking && stop_req) mode_next = SRCC_STOP;
        else if (!waking && halt_req) mode_next = SRCC_HALT;
      end
      SRCC_HALT: if (wake_evt) mode_next = SRCC_RUN;
      SRCC_STOP: if (wake_evt) mode_next = SRCC_RUN;
      default:   mode_next = SRCC_RUN;
    endcase
  end

  // Clock restart delay before the CPU runs again
  assign wake_next = (mode_reg != SRCC_RUN && mode_next == SRCC_RUN) ? 16'(WAKE_CYC) :
                     (waking ? wake_reg - 16'h1 : 16'h0);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_reg <= SRCC_RUN;
      wake_reg <= 16'h0;
    end else begin
      mode_reg <= mode_next;
      wake_reg <= wake_next;
    end
  end

  assign mode       = mode_reg;
  assign cpu_resume = (wake_reg == 16'h1);

  // ****************************************
  // Clock enables
  // ****************************************
  logic [1:0] bus_cnt_reg;
  wire  bus_tick = (bus_cnt_reg == 2'(SRCC_BUS_DIV - 1));

  // Bus phase divider frozen in STOP
  always_ff @(posedge sys_clk) begin
    if (rst) bus_cnt_reg <= SRCC_BUS_CNT_RST;
    else if (!in_stop) bus_cnt_reg <= bus_tick ? 2'h0 : bus_cnt_reg + 2'h1;
  end

  // CPU runs on every system clock, three per bus tick; gated in standby
  assign osc_run       = 1'b1;
  assign pll_run       = ~in_stop;
  assign bus_clk_en    = bus_tick & ~in_stop;
  assign periph_clk_en = ~in_stop;
  assign cpu_clk_en    = ~in_halt & ~in_stop & ~waking & ~sys_reset_reg;

  // Clock output pin: toggles while bus runs, low in STOP
  logic clk_pin_reg;
  always_ff @(posedge sys_clk) begin
    if (rst) clk_pin_reg <= 1'b0;
    else if (in_stop) clk_pin_reg <= 1'b0;
    else if (bus_tick) clk_pin_reg <= ~clk_pin_reg;
  end
  assign clock_output_pin = clk_pin_reg;

  // ****************************************
  // Pin level control
  // ****************************************
  logic [SRCC_CAS_W-1:0] cas_hold_reg;
  logic                  ref_hold_reg;
  logic                  ras_reg;
  wire  normal_pins = (mode_reg == SRCC_RUN) | dma_active;
  wire  halt_pins   = in_halt & ~dma_active;
  wire  grant_float = ~hold_grant_n;

  // Capture DRAM levels on STOP entry, row strobe on HALT entry
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cas_hold_reg <= {SRCC_CAS_W{1'b1}};
      ref_hold_reg <= 1'b1;
      ras_reg      <= 1'b1;
    end else begin
      if (!in_stop) begin
        cas_hold_reg <= cas_core;
        ref_hold_reg <= refresh_core;
      end
      if (!in_halt) ras_reg <= ras_core;
      else if (cbr_done) ras_reg <= 1'b1;
    end
  end

  wire [SRCC_CAS_W-1:0] cas_stop = self_refresh_en ? cas_selfref : cas_hold_reg;
  wire                  ref_stop = self_refresh_en ? refresh_selfref : ref_hold_reg;
  wire [SRCC_CAS_W-1:0] cas_sel  = sys_reset_reg ? {SRCC_CAS_W{1'b1}} :
                                   in_stop ? cas_stop :
                                   halt_pins ? {SRCC_CAS_W{1'b1}} : cas_core;
  wire                  ctl_high = sys_reset_reg | halt_pins | in_stop;

  assign chip_select_lines      = ctl_high ? {SRCC_CS_W{1'b1}} : cs_core;
  assign bus_cycle_start_strobe = ctl_high | bcs_core;
  assign strobe_pins            = ctl_high ? 4'hf : strobe_core;
  assign column_strobe_byte0    = cas_sel[0];
  assign column_strobe_byte1    = cas_sel[1];
  assign column_strobe_byte2    = cas_sel[2];
  assign column_strobe_byte3    = cas_sel[3];
  assign refresh_request_out    = sys_reset_reg ? 1'b1 : (in_stop ? ref_stop : refresh_core);
  assign row_strobe             = sys_reset_reg ? 1'b1 : (normal_pins ? ras_core : ras_reg);
  assign hold_grant_out_n       = sys_reset_reg | hold_grant_core_n;
  assign transfer_grant_lines   = sys_reset_reg ? {SRCC_DACK_W{1'b1}} : dack_core;
  assign serial_tx              = sys_reset_reg | txd_core;
  assign terminal_count_out     = sys_reset_reg | tc_core;
  // Control pins float under hold grant in HALT
  assign ctrl_oe                = ~(halt_pins & grant_float);
  assign data_bus_oe            = normal_pins & ~sys_reset_reg & data_oe_core;
  assign address_oe             = normal_pins & ~sys_reset_reg & addr_oe_core;
  assign general_pins_oe        = sys_reset_reg ? '0 : port_oe_core;
  assign timer_output_a_oe      = ~sys_reset_reg & timer_oe_core[0];
  assign timer_output_b_oe      = ~sys_reset_reg & timer_oe_core[1];

  // ****************************************
  // Checks
  // ****************************************
  sequence s_wake;
    (mode_reg != SRCC_RUN) ##1 (mode_reg == SRCC_RUN);
  endsequence

  property p_halt_cpu;
    @(posedge sys_clk) disable iff (rst) in_halt |-> (!cpu_clk_en && pll_run && periph_clk_en);
  endproperty
  a_halt_cpu: assert property (p_halt_cpu) else $error("HALT clock state wrong");

  property p_stop_clk;
    @(posedge sys_clk) disable iff (rst) in_stop |-> (!pll_run && !bus_clk_en && osc_run);
  endproperty
  a_stop_clk: assert property (p_stop_clk) else $error("STOP clock state wrong");

  property p_bus_ratio;
    @(posedge sys_clk) disable iff (rst) (bus_clk_en && !in_stop) ##1 !in_stop [*2]
      |=> (bus_clk_en || in_stop);
  endproperty
  a_bus_ratio: assert property (p_bus_ratio) else $error("bus clock not one in three");

  property p_halt_pins;
    @(posedge sys_clk) disable iff (rst) (halt_pins && !sys_reset_reg)
      |-> (&chip_select_lines && bus_cycle_start_strobe && !data_bus_oe);
  endproperty
  a_halt_pins: assert property (p_halt_pins) else $error("HALT pin levels wrong");

  property p_ras_refresh;
    @(posedge sys_clk) disable iff (rst)
      (in_halt && cbr_done && !dma_active && !sys_reset_reg) ##1 (in_halt && !dma_active) |-> row_strobe;
  endproperty
  a_ras_refresh: assert property (p_ras_refresh) else $error("row strobe not high after refresh");

  property p_reset_pins;
    @(posedge sys_clk) disable iff (rst) sys_reset_reg
      |-> (hold_grant_out_n && serial_tx && &transfer_grant_lines && !data_bus_oe);
  endproperty
  a_reset_pins: assert property (p_reset_pins) else $error("reset pin levels wrong");

  property p_dbg_force;
    @(posedge sys_clk) disable iff (rst) dbg_force_reset |=> sys_reset;
  endproperty
  a_dbg_force: assert property (p_dbg_force) else $error("forced reset not applied");

  property p_wake_cpu;
    @(posedge sys_clk) disable iff (rst) s_wake |-> !cpu_clk_en;
  endproperty
  a_wake_cpu: assert property (p_wake_cpu) else $error("CPU ran before clocks restarted");

  property p_dma_normal;
    @(posedge sys_clk) disable iff (rst) (dma_active && in_halt && !sys_reset_reg)
      |-> (chip_select_lines == cs_core);
  endproperty
  a_dma_normal: assert property (p_dma_normal) else $error("DMA pins not normal in HALT");
endmodule : srcc_top
`default_nettype wire

// file: srcc_far_model.sv
// Far-side model: an external bus master that takes the bus or runs a DMA transfer.
// Assumes requests come from the bench as levels on sys_clk; slow delays the grant.
`default_nettype none
module srcc_far_model (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic hold_req,
  input  wire logic dma_req,
  input  wire logic slow,
  output logic      hold_grant_n,
  output logic      dma_active
);
  logic [2:0] wait_reg;
  logic [2:0] wait_next;
  logic       ready;

  // Grant after one cycle, or after five when slow, so it never acts at once
  assign ready     = (wait_reg >= (slow ? 3'h5 : 3'h1));
  assign wait_next = ready ? wait_reg : wait_reg + 3'h1;

  // Idle levels: grant released high, no transfer running
  always_ff @(posedge sys_clk) begin
    if (rst || !(hold_req || dma_req)) begin
      wait_reg     <= 3'h0;
      hold_grant_n <= 1'b1;
      dma_active   <= 1'b0;
    end else begin
      wait_reg     <= wait_next;
      hold_grant_n <= !(ready && hold_req);
      dma_active   <= ready && dma_req;
    end
  end
endmodule : srcc_far_model
`default_nettype wire

// file: standby_reset_clock_control_tb.sv
// Self-checking bench for the standby, reset and clock control block.
// Assumes the package, the design files and the far-side model are compiled first.
`default_nettype none
module standby_reset_clock_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import srcc_pkg::*;
  localparam int WAKE = 2;
  logic sys_clk, rst, reset_pin_n, nmi_pin, dbg_force_reset, dbg_mask_reset, dbg_mask_nmi;
  logic halt_req, stop_req, irq_pending, self_refresh_en, dma_active, cbr_done;
  logic hold_grant_n, bcs_core, ras_core, refresh_core, refresh_selfref, hold_grant_core_n;
  logic txd_core, tc_core, data_oe_core, addr_oe_core, hold_req, dma_req, slow;
  logic [6:0] cs_core, chip_select_lines;
  logic [3:0] strobe_core, cas_core, cas_selfref, dack_core, strobe_pins, transfer_grant_lines;
  logic [2:0] port_oe_core, general_pins_oe;
  logic [1:0] timer_oe_core;
  logic bus_clk_en, cpu_clk_en, periph_clk_en, pll_run, osc_run, clock_output_pin, sys_reset;
  logic nmi_req, cpu_resume, bus_cycle_start_strobe, column_strobe_byte0, column_strobe_byte1;
  logic column_strobe_byte2, column_strobe_byte3, row_strobe, refresh_request_out;
  logic hold_grant_out_n, serial_tx, terminal_count_out, ctrl_oe, data_bus_oe, address_oe;
  logic timer_output_a_oe, timer_output_b_oe;
  logic [3:0] cas_pins;
  srcc_mode_t mode;
  int fails, checks, nb, nc, nk, n;

  assign cas_pins = {column_strobe_byte3, column_strobe_byte2, column_strobe_byte1,
                     column_strobe_byte0};
  srcc_top #(.WAKE_CYC(WAKE)) uut (.*);
  srcc_far_model far (.*);

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic step;
    @(posedge sys_clk);
    #1;
  endtask : step

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask : check_val

  // Counts bus ticks, CPU ticks and clock pin toggles over 30 cycles
  task automatic measure;
    logic last;
    nb = 0;
    nc = 0;
    nk = 0;
    last = clock_output_pin;
    repeat (30) begin
      step;
      nb += (bus_clk_en === 1'b1);
      nc += (cpu_clk_en === 1'b1);
      nk += (clock_output_pin !== last);
      last = clock_output_pin;
    end
  endtask : measure

  task automatic check_idle(input string msg);
    check_val(chip_select_lines, 7'h7f, msg);
    check_val(bus_cycle_start_strobe, 1'b1, msg);
    check_val(strobe_pins, 4'hf, msg);
    check_val(data_bus_oe, 1'b0, msg);
  endtask : check_idle

  // Waits for the wake delay to end and the CPU clock to restart
  task automatic wait_resume;
    logic r;
    #1;
    check_val(mode, SRCC_RUN, "mode after wake");
    check_val({pll_run, periph_clk_en}, 2'h3, "clocks back before cpu");
    check_val(cpu_clk_en, 1'b0, "cpu clock before resume");
    n = 0;
    r = 1'b0;
    // Count cycles from the wake edge until the CPU clock runs again
    while (cpu_clk_en !== 1'b1 && n < 40) begin
      r = cpu_resume;
      step;
      n++;
    end
    check_val(n, WAKE, "resume delay");
    check_val(r, 1'b1, "resume pulse before cpu clock");
    check_val(cpu_resume, 1'b0, "resume pulse ends");
  endtask : wait_resume

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset;
    logic last;
    step;
    check_idle("reset strobes");
    check_val({hold_grant_out_n, transfer_grant_lines, serial_tx, terminal_count_out}, 7'h7f,
              "reset grants");
    check_val({cas_pins, row_strobe, sys_reset}, 6'h3f, "reset dram");
    check_val({address_oe, general_pins_oe, timer_output_a_oe, timer_output_b_oe}, 6'h0,
              "reset floats");
    @(posedge sys_clk) rst <= 1'b0;
    n = 0;
    nk = 0;
    last = clock_output_pin;
    while (sys_reset === 1'b1 && n < 20) begin
      step;
      n++;
      nk += (clock_output_pin !== last);
      last = clock_output_pin;
    end
    check_val(nk > 0, 1'b1, "clock pin runs in reset");
    check_val(sys_reset, 1'b0, "reset released");
  endtask : test_reset

  task automatic test_run;
    measure;
    check_val(nb, 30 / SRCC_BUS_DIV, "bus ticks");
    check_val(nc, 30 / SRCC_BUS_DIV * SRCC_CPU_MULT, "cpu ticks");
    check_val(nk, 30 / SRCC_BUS_DIV, "clock pin toggles");
  endtask : test_run

  task automatic test_halt;
    @(posedge sys_clk) halt_req <= 1'b1;
    @(posedge sys_clk) halt_req <= 1'b0;
    step;
    check_val(mode, SRCC_HALT, "halt entry");
    measure;
    check_val(nc, 0, "cpu stopped in halt");
    check_val(nb, 30 / SRCC_BUS_DIV, "bus runs in halt");
    check_val({pll_run, osc_run, periph_clk_en}, 3'h7, "halt clocks");
    check_idle("halt strobes");
    check_val(row_strobe, 1'b0, "row held");
    @(posedge sys_clk) cbr_done <= 1'b1;
    @(posedge sys_clk) cbr_done <= 1'b0;
    step;
    check_val(row_strobe, 1'b1, "row after refresh");
    @(posedge sys_clk) {hold_req, slow} <= 2'h3;
    repeat (8) step;
    check_val(ctrl_oe, 1'b0, "float under grant");
    @(posedge sys_clk) {hold_req, dma_req, slow} <= 3'h2;
    repeat (4) step;
    check_val({chip_select_lines, strobe_pins, data_bus_oe, ctrl_oe},
              {cs_core, strobe_core, data_oe_core, 1'b1}, "pins during dma");
    @(posedge sys_clk) dma_req <= 1'b0;
    repeat (3) step;
    check_idle("halt after dma");
    @(posedge sys_clk) irq_pending <= 1'b1;
    @(posedge sys_clk) irq_pending <= 1'b0;
    wait_resume;
  endtask : test_halt

  task automatic test_stop(input logic sref);
    @(posedge sys_clk) begin
      self_refresh_en <= sref;
      stop_req        <= 1'b1;
    end
    @(posedge sys_clk) stop_req <= 1'b0;
    @(posedge sys_clk) cas_core <= 4'h3;
    step;
    check_val(mode, SRCC_STOP, "stop entry");
    measure;
    check_val(nb + nc + nk, 0, "clocks stopped");
    check_val({pll_run, periph_clk_en, osc_run, clock_output_pin}, 4'h2, "stop clocks");
    check_val({cas_pins, refresh_request_out}, sref ? {cas_selfref, refresh_selfref} : 5'h0a,
              "dram pins in stop");
    @(posedge sys_clk) nmi_pin <= 1'b1;
    n = 0;
    while (nmi_req !== 1'b1 && n < 15) begin
      step;
      n++;
    end
    check_val(nmi_req, 1'b1, "filtered nmi");
    @(posedge sys_clk) nmi_pin <= 1'b0;
    wait_resume;
    repeat (WAKE + 10) step;
    test_run;
    @(posedge sys_clk) cas_core <= 4'h5;
  endtask : test_stop

  task automatic test_debug;
    @(posedge sys_clk) dbg_force_reset <= 1'b1;
    repeat (3) step;
    check_val(sys_reset, 1'b1, "forced reset");
    @(posedge sys_clk) {dbg_force_reset, reset_pin_n} <= 2'h0;
    repeat (2) @(posedge sys_clk);
    reset_pin_n <= 1'b1;
    nk = 0;
    repeat (12) begin
      step;
      nk += (sys_reset === 1'b1);
    end
    check_val(nk, 0, "glitch rejected");
    @(posedge sys_clk) {dbg_mask_reset, dbg_mask_nmi, reset_pin_n, nmi_pin} <= 4'hc;
    repeat (12) @(posedge sys_clk);
    nmi_pin <= 1'b1;
    nk = 0;
    repeat (12) begin
      step;
      nk += (sys_reset === 1'b1) + (nmi_req === 1'b1);
    end
    check_val(nk, 0, "masked reset and nmi");
    @(posedge sys_clk) {reset_pin_n, nmi_pin} <= 2'h2;
    repeat (10) @(posedge sys_clk);
    {dbg_mask_reset, dbg_mask_nmi} <= 2'h0;
  endtask : test_debug

  task automatic summarize;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    {rst, reset_pin_n, nmi_pin, dbg_force_reset, dbg_mask_reset, dbg_mask_nmi} = 6'h30;
    {halt_req, stop_req, irq_pending, self_refresh_en, cbr_done, hold_req, dma_req} = 7'h0;
    {cs_core, bcs_core, strobe_core, cas_core, ras_core} = 17'h5450;
    {refresh_core, cas_selfref, refresh_selfref, hold_grant_core_n} = 7'h16;
    {dack_core, txd_core, tc_core, data_oe_core, addr_oe_core} = 8'h63;
    {port_oe_core, timer_oe_core, slow} = 6'h3e;
    test_reset;
    test_run;
    test_halt;
    test_stop(1'b1);
    test_stop(1'b0);
    test_debug;
    summarize;
  end

  // Watchdog well beyond the expected run length
  initial begin
    #100000;
    fails++;
    $display("[FAIL] %0t watchdog timeout", $time);
    summarize;
  end
endmodule : standby_reset_clock_control_tb
`default_nettype wire
